// ==== phy_mgmt_cfg.svh ====
// Purpose: offsets, field positions, reset values and counts for the management block
// Assumes: 5-bit register addresses as carried by the serial management frame
// Notes: definitions only
`ifndef PHY_MGMT_CFG_SVH
`define PHY_MGMT_CFG_SVH

// register addresses
`define REG_NP_WORD 5'h08
`define REG_MII_CTRL 5'h14
`define REG_SYM_ERR 5'h15
`define REG_INT_CTRL 5'h1b

// partner next-page word fields
`define NP_MSG_BIT 13
`define NP_ACK2_BIT 12
`define NP_TOGGLE_BIT 11

// preamble control fields and values
`define PRE100_BIT 7
`define PRE10_BIT 6
`define MII_LOW_VALUE 6'h01
`define STRAP_PRE100 3'h4
`define STRAP_WAIT 2'h2

// interrupt register layout and event order
`define INT_EN_LSB 8
`define EV_LINK_UP 0
`define EV_REMOTE_FAULT 1
`define EV_LINK_DOWN 2
`define EV_PARTNER_ACK 3
`define EV_PAR_DET_FAULT 4
`define EV_PAGE_RX 5
`define EV_RX_ERROR 6
`define EV_JABBER 7

// error counter
`define ERR_CNT_MAX 16'hffff

// management frame
`define PREAMBLE_BITS 6'h20
`define HDR_BITS 5'h0e
`define DATA_BITS 5'h10
`define FRAME_ST 2'h1
`define OP_READ 2'h2
`define OP_WRITE 2'h1

// receive byte stream
`define SFD_BYTE 8'hd5

`endif

// ==== phy_mgmt_pkg.sv ====
// Purpose: types shared by the management register block and the preamble trimmer
// Assumes: phy_mgmt_cfg.svh holds every number
// Notes: whole-module state lives in one packed struct per module
package phy_mgmt_pkg;

	typedef enum logic [1:0] {MG_IDLE, MG_HDR, MG_TA, MG_DATA} mgmt_state_t;

	typedef enum logic [1:0] {TR_WAIT, TR_DROP, TR_PASS} trim_state_t;

	typedef struct packed {
		logic mdc_s1;
		logic mdc_s2;
		logic mdc_s3;
		logic mdio_s1;
		logic mdio_s2;
		logic [2:0] strap_s1;
		logic [2:0] strap_s2;
		logic [1:0] strap_cnt;
		logic strap_done;
		mgmt_state_t mg_st;
		logic [5:0] pre_cnt;
		logic [4:0] bit_cnt;
		logic [15:0] shift;
		logic is_read;
		logic is_write;
		logic [4:0] reg_sel;
		logic [15:0] rd_shift;
		logic mdio_out;
		logic mdio_oe;
		logic [15:0] np_word;
		logic pre100;
		logic pre10;
		logic [7:0] int_en;
		logic [7:0] int_flag;
		logic [15:0] err_cnt;
		logic irq;
	} regs_state_t;

	typedef struct packed {
		trim_state_t st;
		logic out_valid;
		logic [7:0] out_data;
	} trim_reg_t;

endpackage : phy_mgmt_pkg

// ==== rx_preamble_trim.sv ====
// Purpose: trims receive preamble bytes before the MII according to the restore controls
// Assumes: byte stream from same-clock receive logic, valid held high for a whole frame
// Notes: output lags input by one cycle; dropped bytes simply leave a gap in valid
`timescale 1ns/1ps
`include "phy_mgmt_cfg.svh"

module rx_preamble_trim
	import phy_mgmt_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic in_valid, // receive byte valid, high through the frame
	input wire logic [7:0] in_data, // receive byte
	input wire logic speed_100, // 1 = 100 Mbit/s frame, 0 = 10 Mbit/s
	input wire logic keep_pre_100, // restore full preamble at 100 Mbit/s
	input wire logic keep_pre_10, // restore full preamble at 10 Mbit/s
	output logic out_valid, // trimmed byte valid
	output logic [7:0] out_data // trimmed byte
);

	trim_reg_t s_q;
	trim_reg_t s_d;

	// frame start decides how much preamble to drop; valid low ends the frame
	always_comb begin
		s_d = s_q;
		s_d.out_valid = 1'b0;
		if (!in_valid) begin
			s_d.st = TR_WAIT;
		end else begin
			unique case (s_q.st)
				TR_WAIT: begin
					if (speed_100 && !keep_pre_100) begin
						s_d.st = TR_PASS;
					end else if (!speed_100 && !keep_pre_10 && in_data != `SFD_BYTE) begin
						s_d.st = TR_DROP;
					end else begin
						s_d.st = TR_PASS;
						s_d.out_valid = 1'b1;
						s_d.out_data = in_data;
					end
				end
				TR_DROP: begin
					// hold off until the start delimiter so the frame opens with it
					if (in_data == `SFD_BYTE) begin
						s_d.st = TR_PASS;
						s_d.out_valid = 1'b1;
						s_d.out_data = in_data;
					end
				end
				TR_PASS: begin
					s_d.out_valid = 1'b1;
					s_d.out_data = in_data;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_q <= '{st: TR_WAIT, out_valid: 1'b0, out_data: 8'h00};
		end else begin
			s_q <= s_d;
		end
	end

	assign out_valid = s_q.out_valid;
	assign out_data = s_q.out_data;

endmodule : rx_preamble_trim

// ==== phy_mii_ctrl_irq_regs.sv ====
// Purpose: management registers for next-page word, preamble control, error count, interrupts
// Assumes: serial management bus on mdc/mdio pins; event strobes from same-clock logic
// Notes: mdc must run at most about one eighth of clk_sys because of pin synchronisers
//
// Summary of operation
// - next-page bit 13 reads message page (1) or unformatted page (0); resets 0.
// - next-page bit 12 reads 1 when partner can act on information; resets 0.
// - next-page bit 11 is the received toggle, opposite of previous sent one.
// - at 100 Mbit/s with restore 0 drop one preamble byte; 1 passes all.
// - 100 Mbit/s restore resets to 1 when strap equals 100, else 0.
// - at 10 Mbit/s with restore 0 strip preamble so frame starts at SFD.
// - 16-bit read-only count of symbol-error frames, reset zero, cleared by reading.
// - enable bit 15, reset 0, lets the jabber flag drive the interrupt.
// - enable bit 14, reset 0, lets the receive-error flag raise an interrupt.
// - enable bit 13, reset 0, lets the page-received flag raise an interrupt.
// - enable bit 12, reset 0, lets the parallel-detect fault raise an interrupt.
// - enable bit 11, reset 0, lets the partner-acknowledge flag raise an interrupt.
// - enable bit 10, reset 0, lets the link-down flag raise an interrupt.
// - enable bit 9, reset 0, lets the remote-fault flag raise an interrupt.
// - enable bit 8, reset 0, lets the link-up flag raise an interrupt.
// - low interrupt byte holds sticky event flags, same order, cleared by reading.
`timescale 1ns/1ps
`include "phy_mgmt_cfg.svh"

module phy_mii_ctrl_irq_regs
	import phy_mgmt_pkg::*;
#(
	parameter logic [4:0] PHY_ADDR = 5'h01 // management address this device answers
) (
	input wire logic clk_sys, // system clock, 25 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic mdc, // management clock pin
	input wire logic mdio_in, // management data pin, input side
	output logic mdio_out, // management data pin, output side
	output logic mdio_oe, // management data pin, high while driven
	input wire logic [2:0] strap_config, // configuration strap pins
	input wire logic [7:0] event_pulse, // one-cycle event strobes, bit order of flags
	input wire logic sym_err_frame, // one-cycle strobe per frame with symbol error
	input wire logic np_load, // one-cycle strobe: new partner next-page word
	input wire logic [15:0] np_word_in, // received partner next-page word
	input wire logic rx_in_valid, // receive byte valid, high through frame
	input wire logic [7:0] rx_in_data, // receive byte
	input wire logic speed_100, // 1 = 100 Mbit/s receive
	output logic rx_out_valid, // MII receive byte valid
	output logic [7:0] rx_out_data, // MII receive byte
	output logic irq // interrupt, active high
);

	regs_state_t s_q;
	regs_state_t s_d;

	// read view of the register map; unmapped addresses read zero
	function automatic logic [15:0] read_word(input logic [4:0] a, input regs_state_t s);
		logic [15:0] w;
		w = 16'h0000;
		unique case (a)
			`REG_NP_WORD: begin
				w = s.np_word;
			end
			`REG_MII_CTRL: begin
				w[5:0] = `MII_LOW_VALUE;
				w[`PRE100_BIT] = s.pre100;
				w[`PRE10_BIT] = s.pre10;
			end
			`REG_SYM_ERR: begin
				w = s.err_cnt;
			end
			`REG_INT_CTRL: begin
				w = {s.int_en, s.int_flag};
			end
			default: begin
				w = 16'h0000;
			end
		endcase
		return w;
	endfunction : read_word

	logic mdc_rise;
	logic mdio_bit;
	logic clr_flags;
	logic clr_count;
	logic [15:0] wr_word;
	logic [15:0] err_base;
	logic [13:0] hdr;

	// pin sampling and edge detection: the first stage feeds only the second
	assign mdc_rise = s_q.mdc_s2 & ~s_q.mdc_s3;
	assign mdio_bit = s_q.mdio_s2;
	assign hdr = {s_q.shift[12:0], mdio_bit};
	assign wr_word = {s_q.shift[14:0], mdio_bit};

	// management frame engine, register updates and event capture
	always_comb begin
		s_d = s_q;
		clr_flags = 1'b0;
		clr_count = 1'b0;
		err_base = s_q.err_cnt;

		s_d.mdc_s1 = mdc;
		s_d.mdc_s2 = s_q.mdc_s1;
		s_d.mdc_s3 = s_q.mdc_s2;
		s_d.mdio_s1 = mdio_in;
		s_d.mdio_s2 = s_q.mdio_s1;
		s_d.strap_s1 = strap_config;
		s_d.strap_s2 = s_q.strap_s1;

		// strap is caught after release, once it has passed both synchroniser stages
		if (!s_q.strap_done) begin
			if (s_q.strap_cnt == `STRAP_WAIT) begin
				s_d.pre100 = (s_q.strap_s2 == `STRAP_PRE100);
				s_d.strap_done = 1'b1;
			end else begin
				s_d.strap_cnt = s_q.strap_cnt + 2'h1;
			end
		end

		// every state moves only on a detected mdc rising edge
		if (mdc_rise) begin
			unique case (s_q.mg_st)
				MG_IDLE: begin
					if (mdio_bit) begin
						if (s_q.pre_cnt != `PREAMBLE_BITS) begin
							s_d.pre_cnt = s_q.pre_cnt + 6'h01;
						end
					end else if (s_q.pre_cnt == `PREAMBLE_BITS) begin
						// first start bit after a full preamble
						s_d.mg_st = MG_HDR;
						s_d.shift = 16'h0000;
						s_d.bit_cnt = 5'h01;
					end else begin
						s_d.pre_cnt = 6'h00;
					end
				end
				MG_HDR: begin
					s_d.shift = {s_q.shift[14:0], mdio_bit};
					s_d.bit_cnt = s_q.bit_cnt + 5'h01;
					if (s_q.bit_cnt == `HDR_BITS - 5'h01) begin
						s_d.bit_cnt = 5'h00;
						s_d.reg_sel = hdr[4:0];
						s_d.is_read = 1'b0;
						s_d.is_write = 1'b0;
						s_d.mg_st = MG_TA;
						if (hdr[13:12] == `FRAME_ST && hdr[9:5] == PHY_ADDR) begin
							if (hdr[11:10] == `OP_READ) begin
								s_d.is_read = 1'b1;
								s_d.rd_shift = read_word(hdr[4:0], s_q);
								// read side effects happen as the word is latched
								clr_count = (hdr[4:0] == `REG_SYM_ERR);
								clr_flags = (hdr[4:0] == `REG_INT_CTRL);
							end else if (hdr[11:10] == `OP_WRITE) begin
								s_d.is_write = 1'b1;
							end
						end
						if (!(hdr[13:12] == `FRAME_ST && hdr[9:5] == PHY_ADDR)) begin
							// foreign or malformed frame: still count it out, stay silent
							s_d.is_read = 1'b0;
						end
					end
				end
				MG_TA: begin
					// first turnaround bit left floating, second driven low
					s_d.bit_cnt = s_q.bit_cnt + 5'h01;
					if (s_q.bit_cnt == 5'h00) begin
						s_d.mdio_oe = s_q.is_read;
						s_d.mdio_out = 1'b0;
					end else begin
						s_d.mg_st = MG_DATA;
						s_d.bit_cnt = 5'h00;
						s_d.mdio_out = s_q.rd_shift[15];
						s_d.rd_shift = {s_q.rd_shift[14:0], 1'b0};
					end
				end
				MG_DATA: begin
					s_d.shift = {s_q.shift[14:0], mdio_bit};
					s_d.mdio_out = s_q.rd_shift[15];
					s_d.rd_shift = {s_q.rd_shift[14:0], 1'b0};
					s_d.bit_cnt = s_q.bit_cnt + 5'h01;
					if (s_q.bit_cnt == `DATA_BITS - 5'h01) begin
						s_d.mdio_oe = 1'b0;
						s_d.mdio_out = 1'b0;
						s_d.mg_st = MG_IDLE;
						s_d.pre_cnt = 6'h00;
						s_d.bit_cnt = 5'h00;
						if (s_q.is_write) begin
							unique case (s_q.reg_sel)
								`REG_MII_CTRL: begin
									s_d.pre100 = wr_word[`PRE100_BIT];
									s_d.pre10 = wr_word[`PRE10_BIT];
								end
								`REG_INT_CTRL: begin
									s_d.int_en = wr_word[15:`INT_EN_LSB];
								end
								default: begin
									// read-only or unmapped: write ignored
									s_d.int_en = s_q.int_en;
								end
							endcase
						end
					end
				end
			endcase
		end

		// partner next-page word is replaced whole by the negotiation logic
		if (np_load) begin
			s_d.np_word = np_word_in;
		end

		// an event in the clearing cycle survives: set wins over read-clear
		s_d.int_flag = (clr_flags ? 8'h00 : s_q.int_flag) | event_pulse;

		// counter sticks at full scale rather than wrapping back to a small value
		if (clr_count) begin
			err_base = 16'h0000;
		end
		if (sym_err_frame && err_base != `ERR_CNT_MAX) begin
			s_d.err_cnt = err_base + 16'h0001;
		end else begin
			s_d.err_cnt = err_base;
		end

		// registered so the pin never glitches through the flag and enable gating
		s_d.irq = |(s_d.int_flag & s_d.int_en);
	end

	// state register; all control state has a defined reset value
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_q <= '0;
			s_q.mg_st <= MG_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// receive preamble trimming driven by the two restore controls
	rx_preamble_trim u_trim (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_valid(rx_in_valid),
		.in_data(rx_in_data),
		.speed_100(speed_100),
		.keep_pre_100(s_q.pre100),
		.keep_pre_10(s_q.pre10),
		.out_valid(rx_out_valid),
		.out_data(rx_out_data)
	);

	assign mdio_out = s_q.mdio_out;
	assign mdio_oe = s_q.mdio_oe;
	assign irq = s_q.irq;

endmodule : phy_mii_ctrl_irq_regs

// ==== phy_mii_ctrl_irq_regs_chk.sv ====
// Purpose: port assertions for the management register block
// Assumes: one clk_sys domain, rst synchronous active high
// Notes: irq may fall only near bus traffic, so mdc idle time is counted
`timescale 1ns/1ps
`include "phy_mgmt_cfg.svh"

module phy_mii_ctrl_irq_regs_chk (
	input wire logic clk_sys, // system clock
	input wire logic rst, // sync reset
	input wire logic mdc, // management clock pin
	input wire logic mdio_oe, // data pin enable
	input wire logic [7:0] event_pulse, // event strobes
	input wire logic rx_in_valid, // receive valid
	input wire logic [7:0] rx_in_data, // receive byte
	input wire logic speed_100, // speed select
	input wire logic rx_out_valid, // trimmed valid
	input wire logic [7:0] rx_out_data, // trimmed byte
	input wire logic irq // interrupt
);
	logic [7:0] quiet_q; // cycles since mdc was last high
	logic [7:0] quiet_d;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// saturating idle count; enables are written and flags cleared only inside frames
	always_comb quiet_d = mdc ? 8'h00 : quiet_q + {7'h00, quiet_q != 8'hff};
	always_ff @(posedge clk_sys) quiet_q <= rst ? 8'h00 : quiet_d;

	// a byte that follows another byte of the same frame
	sequence mid_frame;
		$past(rx_in_valid) && rx_in_valid;
	endsequence

	a_reset_quiet: assert property ($fell(rst) |-> !irq && !mdio_oe && !rx_out_valid)
		else $error("outputs active after reset");
	a_trim_valid: assert property (rx_out_valid |-> $past(rx_in_valid))
		else $error("output byte without input byte");
	a_trim_data: assert property (rx_out_valid |-> rx_out_data == $past(rx_in_data))
		else $error("output byte differs from input");
	a_fast_mid: assert property (mid_frame ##0 speed_100 |=> rx_out_valid)
		else $error("fast frame lost a later byte");
	a_slow_sfd: assert property (rx_in_valid && !speed_100 && rx_in_data == `SFD_BYTE
		|=> rx_out_valid)
		else $error("slow frame lost its start byte");
	a_irq_sticky: assert property (irq && quiet_q > 8'h08 |=> irq)
		else $error("irq dropped without bus access");
	a_irq_cause: assert property ($rose(irq) |-> $past(event_pulse != 8'h00) || quiet_q < 8'h08)
		else $error("irq rose without cause");
	a_irq_idle: assert property (!irq && event_pulse == 8'h00 && quiet_q > 8'h08
		|=> !irq)
		else $error("irq rose while idle");
endmodule : phy_mii_ctrl_irq_regs_chk

bind phy_mii_ctrl_irq_regs phy_mii_ctrl_irq_regs_chk i_chk (.clk_sys(clk_sys), .rst(rst),
	.mdc(mdc), .mdio_oe(mdio_oe), .event_pulse(event_pulse), .rx_in_valid(rx_in_valid),
	.rx_in_data(rx_in_data), .speed_100(speed_100), .rx_out_valid(rx_out_valid),
	.rx_out_data(rx_out_data), .irq(irq));

// ==== mdio_station.sv ====
// Purpose: station manager model driving management frames
// Assumes: mdc of 8 clk_sys, 4 high and 4 low, still between frames
// Notes: wire is pulled up when nobody drives it
`timescale 1ns/1ps
`include "phy_mgmt_cfg.svh"

module mdio_station #(
	parameter logic [4:0] ADDR = 5'h01 // device address addressed
) (
	input wire logic clk_sys, // system clock
	input wire logic mdio_out, // device data
	input wire logic mdio_oe, // device drive enable
	output logic mdc, // management clock
	output logic mdio_in // resolved wire level
);
	logic m_oe = 1'b0; // station drives the wire
	logic m_bit = 1'b1;
	logic lvl;

	// resolve the shared wire from both enables
	assign lvl = mdio_oe ? mdio_out : 1'b1;
	assign mdio_in = m_oe ? m_bit : lvl;
	initial mdc = 1'b0;

	// one whole frame; wire sampled just before each rise
	task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [63:0] f;
		f = {32'hffff_ffff, `FRAME_ST, op, ADDR, ra, 2'h2, wd};
		for (int i = 63; i >= 0; i--) begin
			m_oe <= op == `OP_WRITE || i > 17;
			m_bit <= f[i];
			repeat (4) @(posedge clk_sys);
			rd = {rd[14:0], lvl};
			mdc <= 1'b1;
			repeat (4) @(posedge clk_sys);
			mdc <= 1'b0;
		end
		m_oe <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask : xfer
endmodule : mdio_station

// ==== tb.sv ====
// Purpose: self-checking bench for the management register block
// Assumes: strap pins start at the fast-restore setting, changed for the mid-run reset
// Notes: registers reached only through management frames
`timescale 1ns/1ps
`include "phy_mgmt_cfg.svh"

module tb;
	import phy_mgmt_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic mdc, mdio_in, mdio_out, mdio_oe, irq, rx_out_valid;
	logic [7:0] event_pulse = 8'h00;
	logic sym_err_frame = 1'b0;
	logic np_load = 1'b0;
	logic [15:0] np_word_in = 16'h0000;
	logic rx_in_valid = 1'b0;
	logic [7:0] rx_in_data = 8'h00;
	logic speed_100 = 1'b0;
	logic [2:0] strap = `STRAP_PRE100; // strap pins, only changed while reset is held
	logic [7:0] rx_out_data, first_b;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n_out = 0;

	phy_mii_ctrl_irq_regs i_phy_mii_ctrl_irq_regs (.clk_sys(clk_sys), .rst(rst), .mdc(mdc),
		.mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .strap_config(strap),
		.event_pulse(event_pulse), .sym_err_frame(sym_err_frame), .np_load(np_load),
		.np_word_in(np_word_in), .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data),
		.speed_100(speed_100), .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data), .irq(irq));
	mdio_station i_mdio_station (.clk_sys(clk_sys), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.mdc(mdc), .mdio_in(mdio_in));

	always #20 clk_sys = ~clk_sys;

	// hang guard, about half again the expected run
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			errors++;
			end_of_test();
		end
	end

	// count trimmed bytes and keep the first one
	always @(posedge clk_sys) begin
		if (rx_out_valid === 1'b1) begin
			if (n_out == 0) first_b = rx_out_data;
			n_out++;
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] v;
		i_mdio_station.xfer(`OP_READ, a, 16'h0000, v);
		chk(v, exp);
	endtask : rd

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] v;
		i_mdio_station.xfer(`OP_WRITE, a, d, v);
	endtask : wr

	// one-cycle strobes, then two edges so flags and irq settle
	task automatic pulse(input logic [7:0] ev, input logic se, input logic ld, input logic [15:0] w);
		@(posedge clk_sys);
		event_pulse <= ev;
		sym_err_frame <= se;
		np_load <= ld;
		np_word_in <= w;
		@(posedge clk_sys);
		event_pulse <= 8'h00;
		sym_err_frame <= 1'b0;
		np_load <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask : pulse

	// seven preamble bytes, start byte, two payload bytes
	task automatic frame(input logic spd, input logic [15:0] ctl, input int n, input logic [7:0] f);
		wr(`REG_MII_CTRL, ctl);
		n_out = 0;
		speed_100 <= spd;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys);
			rx_in_valid <= 1'b1;
			rx_in_data <= i < 7 ? 8'h55 : (i == 7 ? `SFD_BYTE : 8'(i));
		end
		@(posedge clk_sys);
		rx_in_valid <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk(16'(n_out), 16'(n));
		chk({8'h00, first_b}, {8'h00, f});
	endtask : frame

	task automatic end_of_test;
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd(`REG_MII_CTRL, 16'h0081);
		rd(`REG_NP_WORD, 16'h0000);
		rd(`REG_SYM_ERR, 16'h0000);
		rd(`REG_INT_CTRL, 16'h0000);
		rd(5'h1c, 16'h0000);
		$display("test reset done");
		wr(`REG_NP_WORD, 16'hffff);
		rd(`REG_NP_WORD, 16'h0000);
		pulse(8'h00, 1'b0, 1'b1, 16'h3800);
		rd(`REG_NP_WORD, 16'h3800);
		pulse(8'h00, 1'b0, 1'b1, 16'h1555);
		rd(`REG_NP_WORD, 16'h1555);
		repeat (3) pulse(8'h00, 1'b1, 1'b0, 16'h0000);
		rd(`REG_SYM_ERR, 16'h0003);
		rd(`REG_SYM_ERR, 16'h0000);
		$display("test words done");
		frame(1'b1, 16'h0000, 9, 8'h55);
		frame(1'b1, 16'h0080, 10, 8'h55);
		frame(1'b0, 16'h0000, 3, `SFD_BYTE);
		frame(1'b0, 16'h0040, 10, 8'h55);
		rd(`REG_MII_CTRL, 16'h0041);
		$display("test preamble done");
		for (int k = 0; k < 8; k++) begin
			wr(`REG_INT_CTRL, 16'h0000);
			pulse(8'(1 << k), 1'b0, 1'b0, 16'h0000);
			chk({15'h0000, irq}, 16'h0000);
			rd(`REG_INT_CTRL, 16'(1 << k));
			wr(`REG_INT_CTRL, 16'(1 << (k + 8)));
			pulse(8'(1 << k), 1'b0, 1'b0, 16'h0000);
			chk({15'h0000, irq}, 16'h0001);
			rd(`REG_INT_CTRL, 16'((1 << (k + 8)) | (1 << k)));
			chk({15'h0000, irq}, 16'h0000);
		end
		$display("test interrupts done");
		// second reset with another strap: restore bit must come back clear, enables too
		strap <= 3'h3;
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd(`REG_MII_CTRL, 16'h0001);
		rd(`REG_INT_CTRL, 16'h0000);
		$display("test strap done");
		end_of_test();
	end
endmodule : tb
